// file: clm_pkg.sv
// Constants and state codes for the cache line maintenance unit.
// Assumes a single processor clock; configuration arrives as module parameters.
// Notes on behaviour
// - Write-back flush writes line back, then invalidates
// - Write-back without flush only invalidates, dropping data
// - Match bit invalidates only on address hit
// - Extended address concatenates first and second operand
// - Extended bit used only above 32 address bits
// - Write-back target otherwise is operand sum
// - Write-back ignores the external-cache bit
// - Write-through local invalidate uses first operand only
// - Write-through external request at sum, plus invalidate
// - External bit honoured only on coherent interconnect
// - User-mode data op under MMU raises privilege fault
// - Index is address shifted by line size, masked
// - Dirty flush writes valid words at base plus 4i
// - Matched invalidate finishes in two cycles
// - Flush takes two cycles plus write-back time
// - Data ops ignore data cache enable flag
// - Data op target is always physical
// - Instruction invalidate uses first operand only
// - User-mode instruction invalidate under MMU faults
// - Instruction invalidate ignores instruction cache enable
// - Instruction invalidate virtual only when translating fully
package clm_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] CLM_MSR_OFS = 8'h00;
    localparam logic [7:0] CLM_ESR_OFS = 8'h04;
    localparam logic [7:0] CLM_STAT_OFS = 8'h08;

    localparam int CLM_MSR_USER_BIT = 0;
    localparam int CLM_MSR_XLATE_BIT = 1;
    localparam int CLM_DCACHE_ENABLE_FLAG_BIT = 2;
    localparam int CLM_ICACHE_ENABLE_FLAG_BIT = 3;
    localparam int CLM_MSR_W = 4;
    localparam logic [CLM_MSR_W-1:0] CLM_MSR_RST = 4'h0;

    localparam int CLM_CAUSE_W = 5;
    localparam logic [CLM_CAUSE_W-1:0] CLM_CAUSE_PRIV = 5'h07;
    localparam logic [CLM_CAUSE_W-1:0] CLM_CAUSE_RST = 5'h00;

    // ****************************************************************
    // Configuration codes
    // ****************************************************************
    localparam int CLM_ICON_ACE = 3;
    localparam int CLM_MMU_VIRTUAL = 3;
    localparam int CLM_NARROW_ADDR = 32;
    localparam int CLM_WORD_BYTES = 4;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        CLM_IDLE = 3'h0,
        CLM_LOOK = 3'h1,
        CLM_WB_SEL = 3'h2,
        CLM_WB_DATA = 3'h3,
        CLM_WB_WAIT = 3'h4,
        CLM_EXT_REQ = 3'h5
    } clm_state_e;

endpackage : clm_pkg

// file: clm_cache_line_ops.sv
// Cache line maintenance sequencer for data and instruction cache tags.
// Assumes tag arrays answer a lookup in the same cycle, word data one cycle
// after selection, and memory and external cache accept with ready.
`timescale 1ns/100ps

module clm_cache_line_ops
    import clm_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int DC_WORDS = 4,
    parameter int DC_BYTES = 8192,
    parameter int IC_WORDS = 4,
    parameter int IC_BYTES = 8192,
    parameter bit WRITEBACK_CFG = 1'b1,
    parameter int MMU_CFG = 1,
    parameter int ICON_CFG = 3,
    localparam int DC_LOFS = $clog2(DC_WORDS * CLM_WORD_BYTES),
    localparam int DC_IDX_W = $clog2(DC_BYTES) - DC_LOFS,
    localparam int IC_LOFS = $clog2(IC_WORDS * CLM_WORD_BYTES),
    localparam int IC_IDX_W = $clog2(IC_BYTES) - IC_LOFS,
    localparam int WSEL_W = $clog2(DC_WORDS) + 1
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [7:0] BUS_ADDR,
    input wire logic [31:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    output logic [31:0] BUS_RDATA,
    // Pipeline request
    input wire logic OP_VALID,
    input wire logic OP_ICACHE,
    input wire logic OP_FLUSH,
    input wire logic OP_MATCH,
    input wire logic OP_EA,
    input wire logic OP_EXT,
    input wire logic [31:0] OP_RA,
    input wire logic [31:0] OP_RB,
    input wire logic [ADDR_W-1:0] OP_RA_PHYS,
    output logic OP_READY,
    output logic OP_DONE,
    output logic PRIV_EXC,
    output logic [CLM_CAUSE_W-1:0] EXC_CAUSE,
    // Data cache tag and data array
    output logic DC_LOOKUP,
    output logic DC_TAG_CLR,
    output logic [DC_IDX_W-1:0] DC_IDX,
    input wire logic [ADDR_W-1:0] DC_LINE_ADDR,
    input wire logic DC_DIRTY,
    input wire logic [DC_WORDS-1:0] DC_WORD_VALID,
    output logic [WSEL_W-1:0] DC_WORD_SEL,
    input wire logic [31:0] DC_WORD_DATA,
    // Instruction cache tag array
    output logic IC_TAG_CLR,
    output logic [IC_IDX_W-1:0] IC_IDX,
    // Memory write port
    output logic MEM_WR_VALID,
    output logic [ADDR_W-1:0] MEM_WR_ADDR,
    output logic [31:0] MEM_WR_DATA,
    input wire logic MEM_WR_READY,
    // External coherent cache request
    output logic EXT_REQ_VALID,
    output logic EXT_REQ_FLUSH,
    output logic [ADDR_W-1:0] EXT_REQ_ADDR,
    input wire logic EXT_REQ_READY
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    localparam logic [ADDR_W-1:0] DC_BASE_MASK = {ADDR_W{1'b1}} << DC_LOFS;
    localparam logic [WSEL_W-1:0] WSEL_LAST = WSEL_W'(DC_WORDS - 1);
    localparam logic [WSEL_W-1:0] WSEL_ONE = WSEL_W'(1);
    localparam logic [ADDR_W-1:0] WORD_STEP = ADDR_W'(CLM_WORD_BYTES);

    function automatic logic [ADDR_W-1:0] line_shift(input logic [ADDR_W-1:0] a, input int sh);
        line_shift = a >> sh;
    endfunction : line_shift

    typedef struct packed {
        clm_state_e st;
        logic ready;
        logic done;
        logic priv_exc;
        logic [CLM_CAUSE_W-1:0] cause;
        logic [CLM_MSR_W-1:0] msr;
        logic [31:0] rdata;
        logic flush;
        logic match;
        logic [ADDR_W-1:0] base;
        logic dc_lookup;
        logic dc_tag_clr;
        logic [DC_IDX_W-1:0] dc_idx;
        logic [DC_WORDS-1:0] wmask;
        logic [WSEL_W-1:0] wsel;
        logic ic_tag_clr;
        logic [IC_IDX_W-1:0] ic_idx;
        logic is_ic;
        logic mem_valid;
        logic [ADDR_W-1:0] mem_addr;
        logic [31:0] mem_data;
        logic ext_valid;
        logic ext_flush;
        logic [ADDR_W-1:0] ext_addr;
    } clm_regs_s;

    clm_regs_s r;
    clm_regs_s next_r;

    // ****************************************************************
    // Operand decode
    // ****************************************************************
    logic [31:0] op_sum;
    logic [63:0] op_wide;
    logic [ADDR_W-1:0] dc_target;
    logic [ADDR_W-1:0] ic_target;
    logic ext_active;
    logic priv_fault;

    always_comb begin
        op_sum = OP_RA + OP_RB;
        // External bit is dropped under write-back or without coherency
        ext_active = OP_EXT && !WRITEBACK_CFG && (ICON_CFG == CLM_ICON_ACE);
        // Target is the operand value itself; translation is never applied
        if (WRITEBACK_CFG && OP_MATCH && OP_EA && (ADDR_W > CLM_NARROW_ADDR)) begin
            op_wide = {OP_RA, OP_RB};
        end else if (WRITEBACK_CFG || ext_active) begin
            op_wide = {32'h0, op_sum};
        end else begin
            op_wide = {32'h0, OP_RA};
        end
        dc_target = op_wide[ADDR_W-1:0];
        // Virtual operand only for full virtual translation while active
        if (MMU_CFG == CLM_MMU_VIRTUAL && r.msr[CLM_MSR_XLATE_BIT]) begin
            ic_target = ADDR_W'(OP_RA);
        end else begin
            ic_target = OP_RA_PHYS;
        end
        priv_fault = (MMU_CFG >= 1) && r.msr[CLM_MSR_USER_BIT];
    end

    // ****************************************************************
    // Sequencer and register port
    // ****************************************************************
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.priv_exc = 1'b0;
        next_r.dc_lookup = 1'b0;
        next_r.dc_tag_clr = 1'b0;
        next_r.ic_tag_clr = 1'b0;

        unique case (r.st)
            CLM_IDLE: begin
                if (OP_VALID) begin
                    if (priv_fault) begin
                        next_r.priv_exc = 1'b1;
                        next_r.cause = CLM_CAUSE_PRIV;
                    end else if (OP_ICACHE) begin
                        next_r.is_ic = 1'b1;
                        next_r.ic_idx = IC_IDX_W'(line_shift(ic_target, IC_LOFS));
                        next_r.st = CLM_LOOK;
                    end else begin
                        // Enable flag in the machine status image is not consulted
                        next_r.is_ic = 1'b0;
                        next_r.flush = OP_FLUSH;
                        next_r.match = OP_MATCH;
                        next_r.base = dc_target & DC_BASE_MASK;
                        next_r.dc_idx = DC_IDX_W'(line_shift(dc_target, DC_LOFS));
                        if (ext_active) begin
                            next_r.ext_valid = 1'b1;
                            next_r.ext_flush = OP_FLUSH;
                            next_r.ext_addr = dc_target;
                            next_r.st = CLM_EXT_REQ;
                        end else begin
                            next_r.dc_lookup = 1'b1;
                            next_r.st = CLM_LOOK;
                        end
                    end
                end
            end
            CLM_LOOK: begin
                if (r.is_ic) begin
                    next_r.ic_tag_clr = 1'b1;
                    next_r.done = 1'b1;
                    next_r.st = CLM_IDLE;
                end else if (r.flush && DC_DIRTY) begin
                    // Flush wins if software breaks the flush/match exclusion
                    next_r.wmask = DC_WORD_VALID;
                    next_r.wsel = '0;
                    next_r.st = CLM_WB_SEL;
                end else begin
                    // Two-cycle finish for clean flush, plain and matched invalidate
                    next_r.dc_tag_clr = !(WRITEBACK_CFG && r.match) || (DC_LINE_ADDR == r.base);
                    next_r.done = 1'b1;
                    next_r.st = CLM_IDLE;
                end
            end
            CLM_WB_SEL: begin
                if (r.wmask[r.wsel[WSEL_W-2:0]]) begin
                    next_r.st = CLM_WB_DATA;
                end else if (r.wsel == WSEL_LAST) begin
                    next_r.dc_tag_clr = 1'b1;
                    next_r.done = 1'b1;
                    next_r.st = CLM_IDLE;
                end else begin
                    next_r.wsel = r.wsel + WSEL_ONE;
                end
            end
            CLM_WB_DATA: begin
                next_r.mem_valid = 1'b1;
                next_r.mem_addr = r.base + ADDR_W'(r.wsel) * WORD_STEP;
                next_r.mem_data = DC_WORD_DATA;
                next_r.st = CLM_WB_WAIT;
            end
            CLM_WB_WAIT: begin
                if (MEM_WR_READY) begin
                    next_r.mem_valid = 1'b0;
                    next_r.wmask[r.wsel[WSEL_W-2:0]] = 1'b0;
                    if (r.wsel == WSEL_LAST) begin
                        next_r.dc_tag_clr = 1'b1;
                        next_r.done = 1'b1;
                        next_r.st = CLM_IDLE;
                    end else begin
                        next_r.wsel = r.wsel + WSEL_ONE;
                        next_r.st = CLM_WB_SEL;
                    end
                end
            end
            CLM_EXT_REQ: begin
                if (EXT_REQ_READY) begin
                    next_r.ext_valid = 1'b0;
                    next_r.dc_tag_clr = 1'b1;
                    next_r.done = 1'b1;
                    next_r.st = CLM_IDLE;
                end
            end
            default: begin
                next_r.st = CLM_IDLE;
                next_r.mem_valid = 1'b0;
                next_r.ext_valid = 1'b0;
            end
        endcase
        next_r.ready = (next_r.st == CLM_IDLE);

        // Register port: read data stands the cycle after the strobe
        next_r.rdata = 32'h0;
        if (BUS_WR && BUS_ADDR == CLM_MSR_OFS) begin
            next_r.msr = BUS_WDATA[CLM_MSR_W-1:0];
        end
        if (BUS_RD) begin
            unique case (BUS_ADDR)
                CLM_MSR_OFS: next_r.rdata = 32'(r.msr);
                CLM_ESR_OFS: next_r.rdata = 32'(r.cause);
                CLM_STAT_OFS: next_r.rdata = {31'h0, !r.ready};
                default: next_r.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            r <= '0;
            r.st <= CLM_IDLE;
            r.ready <= 1'b1;
            r.msr <= CLM_MSR_RST;
            r.cause <= CLM_CAUSE_RST;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign BUS_RDATA = r.rdata;
    assign OP_READY = r.ready;
    assign OP_DONE = r.done;
    assign PRIV_EXC = r.priv_exc;
    assign EXC_CAUSE = r.cause;
    assign DC_LOOKUP = r.dc_lookup;
    assign DC_TAG_CLR = r.dc_tag_clr;
    assign DC_IDX = r.dc_idx;
    assign DC_WORD_SEL = r.wsel;
    assign IC_TAG_CLR = r.ic_tag_clr;
    assign IC_IDX = r.ic_idx;
    assign MEM_WR_VALID = r.mem_valid;
    assign MEM_WR_ADDR = r.mem_addr;
    assign MEM_WR_DATA = r.mem_data;
    assign EXT_REQ_VALID = r.ext_valid;
    assign EXT_REQ_FLUSH = r.ext_flush;
    assign EXT_REQ_ADDR = r.ext_addr;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    logic take;
    assign take = OP_VALID && r.ready;

    sequence s_take_plain_dc;
        take && !priv_fault && !OP_ICACHE && !ext_active;
    endsequence

    sequence s_look_clean;
        r.st == CLM_LOOK && !r.is_ic && !(r.flush && DC_DIRTY);
    endsequence

    property p_priv;
        take && priv_fault |=> PRIV_EXC && EXC_CAUSE == CLM_CAUSE_PRIV && !DC_TAG_CLR && !IC_TAG_CLR && OP_READY;
    endproperty
    a_priv: assert property (p_priv) else $error("privilege fault not raised");

    property p_plain_lat;
        s_take_plain_dc ##1 s_look_clean |=> OP_DONE && OP_READY;
    endproperty
    a_plain_lat: assert property (p_plain_lat) else $error("invalidate not done in two cycles");

    property p_match_miss;
        s_look_clean and (r.match && WRITEBACK_CFG && DC_LINE_ADDR != r.base) |=> !DC_TAG_CLR && OP_DONE;
    endproperty
    a_match_miss: assert property (p_match_miss) else $error("mismatched line was invalidated");

    property p_wb_addr;
        MEM_WR_VALID |-> MEM_WR_ADDR[1:0] == 2'h0 && (MEM_WR_ADDR & ~DC_BASE_MASK) == ADDR_W'(DC_WORD_SEL) * WORD_STEP;
    endproperty
    a_wb_addr: assert property (p_wb_addr) else $error("write-back word address wrong");

    property p_ext_hold;
        EXT_REQ_VALID && !EXT_REQ_READY |=> EXT_REQ_VALID && $stable(EXT_REQ_ADDR) && !OP_DONE;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("external request dropped early");

    property p_ic_idx;
        take && !priv_fault && OP_ICACHE |-> ##2 IC_TAG_CLR && OP_DONE && IC_IDX == IC_IDX_W'($past(ic_target, 2) >> IC_LOFS);
    endproperty
    a_ic_idx: assert property (p_ic_idx) else $error("instruction line not invalidated");

    property p_wb_no_ext;
        take && WRITEBACK_CFG |=> !EXT_REQ_VALID [*3];
    endproperty
    a_wb_no_ext: assert property (p_wb_no_ext) else $error("external request under write-back");

    property p_flush_dirty;
        r.st == CLM_LOOK && !r.is_ic && r.flush && DC_DIRTY |=> !OP_DONE && !DC_TAG_CLR && !OP_READY;
    endproperty
    a_flush_dirty: assert property (p_flush_dirty) else $error("dirty flush skipped write-back");

    property p_clear_after_wb;
        MEM_WR_VALID |-> !DC_TAG_CLR && !OP_DONE;
    endproperty
    a_clear_after_wb: assert property (p_clear_after_wb) else $error("line cleared during write-back");

    property p_busy;
        take && !priv_fault |=> !OP_READY && !OP_DONE;
    endproperty
    a_busy: assert property (p_busy) else $error("issuer not stalled while busy");

    property p_lookup;
        s_take_plain_dc |=> DC_LOOKUP && !DC_TAG_CLR && !MEM_WR_VALID;
    endproperty
    a_lookup: assert property (p_lookup) else $error("line state not looked up");

    property p_done_idle;
        OP_DONE |-> OP_READY && !MEM_WR_VALID && !EXT_REQ_VALID;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("retired with a transfer pending");

    property p_ic_only;
        take && !priv_fault && OP_ICACHE |=> !DC_LOOKUP ##1 !DC_TAG_CLR;
    endproperty
    a_ic_only: assert property (p_ic_only) else $error("instruction invalidate touched data cache");

endmodule : clm_cache_line_ops

// file: clm_partner.sv
// Far side of the line maintenance unit: one data cache line, memory write port, external cache.
// Assumes the sequencer reads line state after a lookup and accepts ready at any edge.
`timescale 1ns/100ps

module clm_partner (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [31:0] CFG_LINE_ADDR,
    input wire logic CFG_DIRTY,
    input wire logic [3:0] CFG_VALID,
    input wire logic [127:0] CFG_DATA,
    input wire logic [2:0] DC_WORD_SEL,
    output logic [31:0] DC_LINE_ADDR,
    output logic DC_DIRTY,
    output logic [3:0] DC_WORD_VALID,
    output logic [31:0] DC_WORD_DATA,
    input wire logic MEM_WR_VALID,
    input wire logic [31:0] MEM_WR_ADDR,
    input wire logic [31:0] MEM_WR_DATA,
    output logic MEM_WR_READY,
    input wire logic EXT_REQ_VALID,
    output logic EXT_REQ_READY
);
    logic [31:0] wr_addr_q[$];
    logic [31:0] wr_data_q[$];
    int ext_cnt = 0;
    int pseed = 18;

    assign DC_LINE_ADDR = CFG_LINE_ADDR;
    assign DC_DIRTY = CFG_DIRTY;
    assign DC_WORD_VALID = CFG_VALID;

    always @(posedge REF_CLK) begin
        // Word select out of range gives a toggling pattern, not the last word
        if (DC_WORD_SEL < 3'h4) begin
            DC_WORD_DATA <= CFG_DATA[DC_WORD_SEL[1:0]*32 +: 32];
        end else begin
            DC_WORD_DATA <= ~DC_WORD_DATA;
        end
        // Random stalls make the write-back length vary
        MEM_WR_READY <= RSTN & 1'($random(pseed));
        EXT_REQ_READY <= RSTN & 1'($random(pseed));
        if (RSTN && MEM_WR_VALID && MEM_WR_READY) begin
            wr_addr_q.push_back(MEM_WR_ADDR);
            wr_data_q.push_back(MEM_WR_DATA);
        end
        if (RSTN && EXT_REQ_VALID && EXT_REQ_READY) begin
            ext_cnt <= ext_cnt + 1;
        end
    end
endmodule : clm_partner

// file: clm_cache_line_ops_test.sv
// Self-checking bench for the cache line maintenance unit, write-back build.
// Assumes clm_partner stands in for the cache line store, memory and external cache.
`timescale 1ns/100ps

module clm_cache_line_ops_test;
    import clm_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] b_addr = 8'h00;
    logic [31:0] b_wdata = 32'h0;
    logic b_wr = 1'b0;
    logic b_rd = 1'b0;
    logic op_valid = 1'b0, op_ic = 1'b0, op_fl = 1'b0, op_mt = 1'b0, op_ea = 1'b0, op_ex = 1'b0;
    logic [31:0] op_ra = 32'h0, op_rb = 32'h0, op_phys = 32'h0, c_laddr = 32'h0;
    logic c_dirty = 1'b0;
    logic [3:0] c_valid = 4'h0;
    logic [127:0] c_data = 128'h0;
    logic [31:0] b_rdata, dc_laddr, mem_addr, mem_data, ext_addr, dc_wdata;
    logic op_ready, op_done, priv_exc, dc_lookup, dc_clr, ic_clr, mem_v, mem_rdy, ext_v, ext_fl, ext_rdy, dc_dirty;
    logic [4:0] exc_cause;
    logic [8:0] dc_idx, ic_idx, idx, iidx;
    logic [3:0] dc_wvalid;
    logic [2:0] dc_wsel;
    logic tclr, iclr, exc;
    int seed = 18;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    int timer = 0;

    clm_cache_line_ops clm_cache_line_ops_i (
        .REF_CLK(ref_clk), .RSTN(rstn), .BUS_ADDR(b_addr), .BUS_WDATA(b_wdata), .BUS_WR(b_wr),
        .BUS_RD(b_rd), .BUS_RDATA(b_rdata), .OP_VALID(op_valid), .OP_ICACHE(op_ic), .OP_FLUSH(op_fl),
        .OP_MATCH(op_mt), .OP_EA(op_ea), .OP_EXT(op_ex), .OP_RA(op_ra), .OP_RB(op_rb), .OP_RA_PHYS(op_phys),
        .OP_READY(op_ready), .OP_DONE(op_done), .PRIV_EXC(priv_exc), .EXC_CAUSE(exc_cause),
        .DC_LOOKUP(dc_lookup), .DC_TAG_CLR(dc_clr), .DC_IDX(dc_idx), .DC_LINE_ADDR(dc_laddr),
        .DC_DIRTY(dc_dirty), .DC_WORD_VALID(dc_wvalid), .DC_WORD_SEL(dc_wsel), .DC_WORD_DATA(dc_wdata),
        .IC_TAG_CLR(ic_clr), .IC_IDX(ic_idx), .MEM_WR_VALID(mem_v), .MEM_WR_ADDR(mem_addr),
        .MEM_WR_DATA(mem_data), .MEM_WR_READY(mem_rdy), .EXT_REQ_VALID(ext_v), .EXT_REQ_FLUSH(ext_fl),
        .EXT_REQ_ADDR(ext_addr), .EXT_REQ_READY(ext_rdy)
    );

    clm_partner clm_partner_i (
        .REF_CLK(ref_clk), .RSTN(rstn), .CFG_LINE_ADDR(c_laddr), .CFG_DIRTY(c_dirty), .CFG_VALID(c_valid),
        .CFG_DATA(c_data), .DC_WORD_SEL(dc_wsel), .DC_LINE_ADDR(dc_laddr), .DC_DIRTY(dc_dirty),
        .DC_WORD_VALID(dc_wvalid), .DC_WORD_DATA(dc_wdata), .MEM_WR_VALID(mem_v), .MEM_WR_ADDR(mem_addr),
        .MEM_WR_DATA(mem_data), .MEM_WR_READY(mem_rdy), .EXT_REQ_VALID(ext_v), .EXT_REQ_READY(ext_rdy)
    );

    always #2.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        timer <= timer + 1;
        if (timer == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] exp_idx(input logic [31:0] a);
        return (a >> 4) & 32'h000001FF;
    endfunction : exp_idx

    task automatic chk_val(input string name, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask : chk_val

    task automatic chk_flag(input string name, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", name, e, g);
        end
    endtask : chk_flag

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        b_wr <= 1'b1;
        b_addr <= a;
        b_wdata <= d;
        @(posedge ref_clk);
        b_wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        b_rd <= 1'b1;
        b_addr <= a;
        @(posedge ref_clk);
        b_rd <= 1'b0;
        #1;
        d = b_rdata;
    endtask : bus_rd

    // Issues one operation and follows it to retirement or fault
    task automatic do_op(input logic ic, fl, mt, ea, ex, input logic [31:0] ra, rb);
        @(posedge ref_clk);
        op_valid <= 1'b1;
        {op_ic, op_fl, op_mt, op_ea, op_ex} <= {ic, fl, mt, ea, ex};
        op_ra <= ra;
        op_rb <= rb;
        op_phys <= ra ^ 32'h00005A50;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        tclr = 1'b0;
        iclr = 1'b0;
        cyc = 1;
        #1;
        forever begin
            if (dc_clr === 1'b1) begin
                tclr = 1'b1;
                idx = dc_idx;
            end
            if (ic_clr === 1'b1) begin
                iclr = 1'b1;
                iidx = ic_idx;
            end
            if (op_done === 1'b1 || priv_exc === 1'b1 || cyc > 100) break;
            @(posedge ref_clk);
            #1;
            cyc++;
        end
        exc = priv_exc;
    endtask : do_op

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] d, ra, rb, t;
        int n;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        bus_rd(CLM_MSR_OFS, d);
        chk_val("msr reset", 32'h0, d);
        bus_wr(CLM_MSR_OFS, 32'h0000000E);
        bus_rd(CLM_MSR_OFS, d);
        chk_val("msr", 32'h0000000E, d);
        bus_wr(CLM_ESR_OFS, 32'h0000001F);
        bus_rd(CLM_ESR_OFS, d);
        chk_val("esr", 32'h0, d);
        bus_rd(8'h40, d);
        chk_val("unmapped", 32'h0, d);
        bus_rd(CLM_STAT_OFS, d);
        chk_val("idle status", 32'h0, d);
        $display("Test registers finished");
        // Invalidate, matched hit and matched miss, with enables and translation on
        for (int k = 0; k < 12; k++) begin
            ra = $random(seed);
            rb = $random(seed);
            t = ra + rb;
            c_laddr <= (k % 3 == 2) ? (t & 32'hFFFFFFF0) ^ 32'h00010000 : t & 32'hFFFFFFF0;
            c_dirty <= 1'b1;
            do_op(1'b0, 1'b0, k % 3 != 0, k[2], k[0], ra, rb);
            chk_val("cycles", 32'h2, cyc);
            chk_flag("clear", k % 3 != 2, tclr);
            if (tclr === 1'b1) chk_val("index", exp_idx(t), {23'h0, idx});
            chk_val("ext", 32'h0, clm_partner_i.ext_cnt);
            chk_val("writes", 32'h0, clm_partner_i.wr_addr_q.size());
        end
        $display("Test invalidate finished");
        // Flushes: full, random and clean lines, memory stalling at random
        for (int k = 0; k < 5; k++) begin
            ra = $random(seed);
            rb = $random(seed);
            t = (ra + rb) & 32'hFFFFFFF0;
            c_laddr <= t;
            c_dirty <= (k != 4);
            c_valid <= (k == 0) ? 4'hF : 4'($random(seed));
            c_data <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            clm_partner_i.wr_addr_q.delete();
            clm_partner_i.wr_data_q.delete();
            do_op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, ra, rb);
            n = 0;
            for (int i = 0; i < 4; i++) if (c_dirty && c_valid[i]) begin
                chk_val("wb addr", t + 4 * i, clm_partner_i.wr_addr_q[n]);
                chk_val("wb data", c_data[i*32 +: 32], clm_partner_i.wr_data_q[n]);
                n++;
            end
            chk_val("wb count", n, clm_partner_i.wr_addr_q.size());
            chk_flag("clear", 1'b1, tclr);
            if (c_dirty) chk_flag("wb cycles", 1'b1, cyc >= 2 + n);
            else chk_val("cycles", 32'h2, cyc);
        end
        $display("Test flush finished");
        // Instruction cache: physical address used, first operand value and second operand ignored
        for (int k = 0; k < 3; k++) begin
            ra = $random(seed);
            do_op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ra, $random(seed));
            chk_val("cycles", 32'h2, cyc);
            chk_flag("iclear", 1'b1, iclr);
            chk_val("iindex", exp_idx(ra ^ 32'h00005A50), {23'h0, iidx});
            chk_flag("dclear", 1'b0, tclr);
        end
        $display("Test icache finished");
        // User mode faults both operations and leaves the caches alone
        bus_wr(CLM_MSR_OFS, 32'h00000001);
        for (int k = 0; k < 2; k++) begin
            do_op(k[0], 1'b0, 1'b0, 1'b0, 1'b0, ra, rb);
            chk_flag("fault", 1'b1, exc);
            chk_val("fault cycles", 32'h1, cyc);
            chk_flag("no clear", 1'b0, tclr | iclr);
            chk_val("cause", {27'h0, CLM_CAUSE_PRIV}, {27'h0, exc_cause});
        end
        bus_wr(CLM_MSR_OFS, 32'h0);
        do_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ra, rb);
        chk_flag("supervisor", 1'b0, exc);
        chk_flag("clear", 1'b1, tclr);
        $display("Test privilege finished");
        end_of_test();
    end
endmodule : clm_cache_line_ops_test
